// ### pkg/vrx_defines.svh
// Register offsets, field positions and reset values of the voice receive buffer
`ifndef VRX_DEFINES_SVH
`define VRX_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define VRX_A_DATA 16'h2760
`define VRX_A_MUTE 16'h2761
`define VRX_A_CTL 16'h2762
`define VRX_A_RP 16'h2763
`define VRX_A_WP 16'h2764
`define VRX_A_LEN 16'h2765
`define VRX_A_IST 16'h2766
`define VRX_A_IMSK 16'h2767
`define VRX_A_STS 16'h276A

// ****************************************************************
// Field positions
// ****************************************************************
`define VRX_CTL_FILL 0
`define VRX_CTL_CLR 1
`define VRX_CTL_MUTE 2
`define VRX_CTL_KICK 3
`define VRX_STS_POP 2
`define VRX_STS_PSH 3
`define VRX_STS_ZERO 4
`define VRX_EV_DONE 0
`define VRX_EV_OVF 1
`define VRX_EV_UNF 2
`define VRX_EV_FILL 3
`define VRX_EV_NUM 4

// ****************************************************************
// Reset values and sizes
// ****************************************************************
`define VRX_RST_BYTE 8'h00
`define VRX_RST_EV 4'h0
`define VRX_AW 7
`define VRX_DEPTH 128
`define VRX_FILL_LAST 7'h7F
`define VRX_PTR_INC 8'h01

`endif

// ### pkg/vrx_pkg.sv
// Types shared by the voice receive buffer design
`default_nettype none
package vrx_pkg;

  typedef enum logic {VRX_DMA_IDLE, VRX_DMA_RUN} vrx_dma_state_type;
  typedef enum logic {VRX_FILL_IDLE, VRX_FILL_BUSY} vrx_fill_state_type;

endpackage : vrx_pkg
`default_nettype wire

// ### core/vrx_fifo_dma.sv
// Voice receive buffer with DMA from the MAC receive FIFO and decoder drain
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "vrx_defines.svh"

module vrx_fifo_dma (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [15:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  output logic [7:0] BUS_RDATA,
  output logic IRQ,
  // MAC receive FIFO
  input wire logic [7:0] MRX_DATA,
  input wire logic MRX_VALID,
  output logic MRX_POP,
  // Voice decoder
  input wire logic DEC_REQ,
  output logic [7:0] DEC_DATA,
  output logic DEC_VALID
);

  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction : hit

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] buf_ff [0:`VRX_DEPTH-1];
  logic [7:0] rp_ff, wp_ff, mute_ff, len_ff, cnt_ff, hold_d_ff, rdata_ff;
  logic [7:0] dec_data_ff, mem_rd;
  logic mute_sel_ff, push_act_ff, pop_act_ff, hold_v_ff, mrx_pop_ff;
  logic dec_valid_ff, irq_ff, ovf_ff, unf_ff, dma_done, fill_done;
  logic [6:0] fill_idx_ff;
  logic [`VRX_EV_NUM-1:0] ev_sts_ff, ev_msk_ff, ev_set;
  vrx_pkg::vrx_dma_state_type dma_st_ff;
  vrx_pkg::vrx_fill_state_type fill_st_ff;
  logic wr_data, rd_data, wr_ctl, wr_rp, wr_wp, do_clr, do_fill, do_kick;
  logic full, empty, fill_busy, push_cpu, push_dma, push, pop_cpu, pop_dec;
  logic pop, ovf_evt, unf_evt, dec_serve, dma_issue;
  logic [7:0] push_byte;

  // ****************************************************************
  // Decode and buffer state
  // ****************************************************************
  assign wr_data = BUS_WR && hit(BUS_ADDR, `VRX_A_DATA);
  assign rd_data = BUS_RD && hit(BUS_ADDR, `VRX_A_DATA);
  assign wr_ctl = BUS_WR && hit(BUS_ADDR, `VRX_A_CTL);
  assign wr_rp = BUS_WR && hit(BUS_ADDR, `VRX_A_RP);
  assign wr_wp = BUS_WR && hit(BUS_ADDR, `VRX_A_WP);
  assign do_clr = wr_ctl && BUS_WDATA[`VRX_CTL_CLR];
  assign do_fill = wr_ctl && BUS_WDATA[`VRX_CTL_FILL];
  assign do_kick = wr_ctl && BUS_WDATA[`VRX_CTL_KICK];

  // Bit 7 of each pointer only tells laps apart
  assign full = (wp_ff[6:0] == rp_ff[6:0]) && (wp_ff[7] != rp_ff[7]);
  assign empty = (wp_ff == rp_ff);
  assign fill_busy = (fill_st_ff == vrx_pkg::VRX_FILL_BUSY);
  assign mem_rd = buf_ff[rp_ff[6:0]];

  // ****************************************************************
  // Push and pop arbitration
  // ****************************************************************
  // Software cannot wait, so its accesses win; DMA and decoder retry later
  assign push_cpu = wr_data && !fill_busy && !full;
  assign push_dma = hold_v_ff && !BUS_WR && !fill_busy && !full;
  assign push = push_cpu || push_dma;
  assign push_byte = push_cpu ? BUS_WDATA : hold_d_ff;
  assign pop_cpu = rd_data && !fill_busy && !empty;
  assign pop_dec = DEC_REQ && !mute_sel_ff && !BUS_RD && !BUS_WR
                   && !fill_busy && !empty;
  assign pop = pop_cpu || pop_dec;
  assign ovf_evt = wr_data && !fill_busy && full;
  assign unf_evt = (rd_data || (DEC_REQ && !mute_sel_ff)) && !fill_busy && empty;
  assign dec_serve = (DEC_REQ && mute_sel_ff) || pop_dec;

  // ****************************************************************
  // Buffer storage
  // ****************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (fill_busy)
      buf_ff[fill_idx_ff] <= mute_ff;
    else if (push)
      buf_ff[wp_ff[6:0]] <= push_byte;
  end

  // ****************************************************************
  // Pointers
  // ****************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      rp_ff <= `VRX_RST_BYTE;
    else if (do_clr)
      rp_ff <= `VRX_RST_BYTE;
    else if (wr_rp)
      rp_ff <= BUS_WDATA;
    else if (pop)
      rp_ff <= rp_ff + `VRX_PTR_INC;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      wp_ff <= `VRX_RST_BYTE;
    else if (do_clr)
      wp_ff <= `VRX_RST_BYTE;
    else if (wr_wp)
      wp_ff <= BUS_WDATA;
    else if (push)
      wp_ff <= wp_ff + `VRX_PTR_INC;
  end

  // ****************************************************************
  // Overflow and underflow status
  // ****************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST || do_clr)
    begin
      ovf_ff <= 1'b0;
      unf_ff <= 1'b0;
    end
    else
    begin
      ovf_ff <= ovf_ff || ovf_evt;
      unf_ff <= unf_ff || unf_evt;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      mute_ff <= `VRX_RST_BYTE;
      mute_sel_ff <= 1'b0;
      len_ff <= `VRX_RST_BYTE;
      ev_msk_ff <= `VRX_RST_EV;
    end
    else if (BUS_WR)
    begin
      if (hit(BUS_ADDR, `VRX_A_MUTE))
        mute_ff <= BUS_WDATA;
      if (wr_ctl)
        mute_sel_ff <= BUS_WDATA[`VRX_CTL_MUTE];
      if (hit(BUS_ADDR, `VRX_A_LEN))
        len_ff <= BUS_WDATA;
      if (hit(BUS_ADDR, `VRX_A_IMSK))
        ev_msk_ff <= BUS_WDATA[`VRX_EV_NUM-1:0];
    end
  end

  // ****************************************************************
  // Mute fill sequencer
  // ****************************************************************
  assign fill_done = fill_busy && (fill_idx_ff == `VRX_FILL_LAST);

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      fill_st_ff <= vrx_pkg::VRX_FILL_IDLE;
      fill_idx_ff <= '0;
    end
    else
    begin
      case (fill_st_ff)
        vrx_pkg::VRX_FILL_IDLE:
        begin
          fill_idx_ff <= '0;
          if (do_fill)
            fill_st_ff <= vrx_pkg::VRX_FILL_BUSY;
        end
        vrx_pkg::VRX_FILL_BUSY:
        begin
          fill_idx_ff <= fill_idx_ff + 7'h01;
          if (fill_done)
            fill_st_ff <= vrx_pkg::VRX_FILL_IDLE;
        end
        default:
          fill_st_ff <= vrx_pkg::VRX_FILL_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Receive DMA
  // ****************************************************************
  // One pop every third cycle at most: the pop is registered, so the byte
  // is caught in the cycle the pop is seen and parked until a push slot
  assign dma_issue = (dma_st_ff == vrx_pkg::VRX_DMA_RUN) && (cnt_ff != 8'h00)
                     && MRX_VALID && !mrx_pop_ff && !hold_v_ff;
  assign dma_done = (dma_st_ff == vrx_pkg::VRX_DMA_RUN) && (cnt_ff == 8'h00)
                    && !mrx_pop_ff && !hold_v_ff;

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      dma_st_ff <= vrx_pkg::VRX_DMA_IDLE;
      cnt_ff <= `VRX_RST_BYTE;
    end
    else
    begin
      case (dma_st_ff)
        vrx_pkg::VRX_DMA_IDLE:
          if (do_kick)
          begin
            dma_st_ff <= vrx_pkg::VRX_DMA_RUN;
            cnt_ff <= len_ff;
          end
        vrx_pkg::VRX_DMA_RUN:
        begin
          if (dma_issue)
            cnt_ff <= cnt_ff - 8'h01;
          if (dma_done)
            dma_st_ff <= vrx_pkg::VRX_DMA_IDLE;
        end
        default:
          dma_st_ff <= vrx_pkg::VRX_DMA_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      mrx_pop_ff <= 1'b0;
      hold_v_ff <= 1'b0;
      hold_d_ff <= `VRX_RST_BYTE;
    end
    else
    begin
      mrx_pop_ff <= dma_issue;
      if (mrx_pop_ff)
      begin
        hold_v_ff <= 1'b1;
        hold_d_ff <= MRX_DATA;
      end
      else if (push_dma)
        hold_v_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Activity flags, decoder output and read data
  // ****************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      push_act_ff <= 1'b0;
      pop_act_ff <= 1'b0;
      dec_valid_ff <= 1'b0;
      dec_data_ff <= `VRX_RST_BYTE;
    end
    else
    begin
      push_act_ff <= push;
      pop_act_ff <= pop;
      dec_valid_ff <= dec_serve;
      if (dec_serve)
        dec_data_ff <= mute_sel_ff ? mute_ff : mem_rd;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      rdata_ff <= `VRX_RST_BYTE;
    else if (BUS_RD)
    begin
      case (BUS_ADDR)
        // An empty buffer answers with the mute byte rather than stale data
        `VRX_A_DATA: rdata_ff <= empty ? mute_ff : mem_rd;
        `VRX_A_MUTE: rdata_ff <= mute_ff;
        `VRX_A_CTL: rdata_ff <= 8'(mute_sel_ff) << `VRX_CTL_MUTE;
        `VRX_A_RP: rdata_ff <= rp_ff;
        `VRX_A_WP: rdata_ff <= wp_ff;
        `VRX_A_LEN: rdata_ff <= len_ff;
        `VRX_A_IST: rdata_ff <= {4'h0, ev_sts_ff};
        `VRX_A_IMSK: rdata_ff <= {4'h0, ev_msk_ff};
        `VRX_A_STS: rdata_ff <= {3'h0, fill_busy, push_act_ff,
                                 pop_act_ff, 2'h0};
        default: rdata_ff <= `VRX_RST_BYTE;
      endcase
    end
    else
      rdata_ff <= `VRX_RST_BYTE;
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign ev_set[`VRX_EV_DONE] = dma_done;
  assign ev_set[`VRX_EV_OVF] = ovf_evt;
  assign ev_set[`VRX_EV_UNF] = unf_evt;
  assign ev_set[`VRX_EV_FILL] = fill_done;

  genvar gi;
  generate
    for (gi = 0; gi < `VRX_EV_NUM; gi++)
    begin : g_ev
      // A new event outranks a write-one-to-clear in the same cycle
      always_ff @(posedge REF_CLK)
      begin
        if (SYS_RST)
          ev_sts_ff[gi] <= 1'b0;
        else if (ev_set[gi])
          ev_sts_ff[gi] <= 1'b1;
        else if (BUS_WR && hit(BUS_ADDR, `VRX_A_IST) && BUS_WDATA[gi])
          ev_sts_ff[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(ev_sts_ff & ev_msk_ff);
  end

  assign BUS_RDATA = rdata_ff;
  assign IRQ = irq_ff;
  assign MRX_POP = mrx_pop_ff;
  assign DEC_DATA = dec_data_ff;
  assign DEC_VALID = dec_valid_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_kick;
    do_kick && (dma_st_ff == vrx_pkg::VRX_DMA_IDLE);
  endsequence

  sequence s_fill_start;
    do_fill && !fill_busy;
  endsequence

  property p_push_order;
    @(posedge REF_CLK) disable iff (SYS_RST)
    push_cpu |=> (wp_ff == $past(wp_ff) + `VRX_PTR_INC)
                 && (buf_ff[$past(wp_ff[6:0])] == $past(BUS_WDATA));
  endproperty
  a_push_order: assert property (p_push_order) else $error("push lost");

  property p_pop_data;
    @(posedge REF_CLK) disable iff (SYS_RST)
    pop_cpu |=> (BUS_RDATA == $past(mem_rd)) && (rp_ff == $past(rp_ff) + `VRX_PTR_INC);
  endproperty
  a_pop_data: assert property (p_pop_data) else $error("pop data wrong");

  property p_mute_out;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (DEC_REQ && mute_sel_ff) |=> DEC_VALID && (DEC_DATA == $past(mute_ff))
                                 && ($past(BUS_RD || BUS_WR) || $stable(rp_ff));
  endproperty
  a_mute_out: assert property (p_mute_out) else $error("mute not sent");

  property p_kick_len;
    @(posedge REF_CLK) disable iff (SYS_RST)
    s_kick |=> (dma_st_ff == vrx_pkg::VRX_DMA_RUN) && (cnt_ff == $past(len_ff));
  endproperty
  a_kick_len: assert property (p_kick_len) else $error("dma start wrong");

  property p_dma_copy;
    @(posedge REF_CLK) disable iff (SYS_RST)
    MRX_POP |=> hold_v_ff && (hold_d_ff == $past(MRX_DATA));
  endproperty
  a_dma_copy: assert property (p_dma_copy) else $error("dma byte lost");

  property p_clr;
    @(posedge REF_CLK) disable iff (SYS_RST)
    do_clr |=> (rp_ff == 8'h00) && (wp_ff == 8'h00) && !ovf_ff && !unf_ff;
  endproperty
  a_clr: assert property (p_clr) else $error("clear failed");

  property p_fill;
    @(posedge REF_CLK) disable iff (SYS_RST)
    s_fill_start |=> fill_busy [*8] ##[120:121] !fill_busy;
  endproperty
  a_fill: assert property (p_fill) else $error("fill length wrong");

  property p_full_refuse;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (wr_data && full) |=> $stable(wp_ff) && (ovf_ff || $past(fill_busy));
  endproperty
  a_full_refuse: assert property (p_full_refuse) else $error("full not held");

  property p_activity;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (push || pop) |=> (push_act_ff == $past(push)) && (pop_act_ff == $past(pop));
  endproperty
  a_activity: assert property (p_activity) else $error("activity flag wrong");

endmodule : vrx_fifo_dma
`default_nettype wire

// ### tb/vrx_mac_model.sv
// Behavioural MAC receive FIFO that feeds the voice DMA
`timescale 1ns/100ps
`default_nettype none
module vrx_mac_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link
  input wire logic stall,
  input wire logic pop,
  output logic [7:0] data,
  output logic valid
);
  logic [7:0] mem [0:255];
  logic [7:0] head_ff = 8'h00;
  logic [7:0] tail_ff = 8'h00;
  logic [7:0] last_ff = 8'h00;
  // Empty FIFO shows the inverse of the last byte so a stale read is caught
  assign valid = (head_ff != tail_ff) && !stall;
  assign data = (head_ff != tail_ff) ? mem[head_ff] : ~last_ff;
  always @(posedge clk)
  begin
    if (rst)
    begin
      head_ff <= 8'h00;
    end
    else if (pop && (head_ff != tail_ff))
    begin
      last_ff <= mem[head_ff];
      head_ff <= head_ff + 8'h01;
    end
  end
  task automatic load(input logic [7:0] b);
    mem[tail_ff] = b;
    tail_ff = tail_ff + 8'h01;
  endtask : load
endmodule : vrx_mac_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the voice receive buffer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] e;} vrx_tb_row_type;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stall = 1'b0;
  logic dec_req = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic [7:0] mrx_data;
  logic mrx_valid;
  logic mrx_pop;
  logic [7:0] dec_data;
  logic dec_valid;
  logic [7:0] v;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  int pops = 0;
  vrx_tb_row_type rows [0:11] = '{
    '{16'h2761, 8'hA5, 8'hA5}, '{16'h2762, 8'hF4, 8'h04}, '{16'h2762, 8'h00, 8'h00},
    '{16'h2763, 8'h85, 8'h85}, '{16'h2764, 8'h85, 8'h85}, '{16'h2763, 8'h00, 8'h00},
    '{16'h2764, 8'h00, 8'h00}, '{16'h2765, 8'h03, 8'h03}, '{16'h2767, 8'h0F, 8'h0F},
    '{16'h2767, 8'h00, 8'h00}, '{16'h2770, 8'h12, 8'h00}, '{16'h276A, 8'hFF, 8'h00}};

  always #4 ref_clk = ~ref_clk;

  // Count the bytes the DMA takes from the far side
  always @(posedge ref_clk)
  begin
    if (mrx_pop)
      pops++;
  end

  vrx_fifo_dma dut (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .BUS_ADDR(addr), .BUS_WDATA(wdata),
    .BUS_WR(wr), .BUS_RD(rd), .BUS_RDATA(rdata), .IRQ(irq), .MRX_DATA(mrx_data),
    .MRX_VALID(mrx_valid), .MRX_POP(mrx_pop), .DEC_REQ(dec_req), .DEC_DATA(dec_data),
    .DEC_VALID(dec_valid));

  vrx_mac_model mac (
    .clk(ref_clk), .rst(sys_rst), .stall(stall), .pop(mrx_pop), .data(mrx_data),
    .valid(mrx_valid));

  // ****************
  // Bus and check tasks
  // ****************
  task automatic results();
    if ((miscompares == 0) && (comparisons > 0))
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One strobe per call; consecutive calls give back-to-back accesses
  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
  endtask : bus

  task automatic idle(input int c);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (c) @(posedge ref_clk);
  endtask : idle

  // Read data stand only in the cycle after the strobe
  task automatic rdv(input logic [15:0] a, output logic [7:0] d);
    bus(1'b0, 1'b1, a, 8'h00);
    #1;
    d = rdata;
  endtask : rdv

  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    rdv(a, v);
    chk(v, e);
  endtask : rdc

  task automatic dec(input logic ok, input logic [7:0] e);
    wr <= 1'b0;
    rd <= 1'b0;
    dec_req <= 1'b1;
    @(posedge ref_clk);
    dec_req <= 1'b0;
    #1;
    chk({7'h00, dec_valid}, {7'h00, ok});
    if (ok)
      chk(dec_data, e);
  endtask : dec

  // Bounded poll; the count is the number of reads before the stop value
  task automatic poll(input logic [15:0] a, input logic [7:0] m, input logic [7:0] s,
                      output int c);
    c = 0;
    rdv(a, v);
    while ((v & m) !== s)
    begin
      c++;
      if (c > 300)
      begin
        miscompares++;
        results();
      end
      rdv(a, v);
    end
  endtask : poll

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 1; i < 8; i++)
      rdc(16'h2760 + 16'(i), 8'h00);
    rdc(16'h276A, 8'h00);
    foreach (rows[i])
    begin
      bus(1'b1, 1'b0, rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].e);
    end
    bus(1'b1, 1'b0, 16'h2760, 8'h11);
    rdc(16'h276A, 8'h08);
    bus(1'b1, 1'b0, 16'h2760, 8'h22);
    bus(1'b1, 1'b0, 16'h2760, 8'h33);
    rdc(16'h2764, 8'h03);
    rdc(16'h2760, 8'h11);
    rdc(16'h276A, 8'h04);
    rdc(16'h2760, 8'h22);
    rdc(16'h2763, 8'h02);
    dec(1'b1, 8'h33);
    dec(1'b0, 8'h00);
    rdc(16'h2766, 8'h04);
    chk({7'h00, irq}, 8'h00);
    bus(1'b1, 1'b0, 16'h2767, 8'h04);
    idle(2);
    #1;
    chk({7'h00, irq}, 8'h01);
    bus(1'b1, 1'b0, 16'h2766, 8'h04);
    idle(2);
    #1;
    chk({7'h00, irq}, 8'h00);
    bus(1'b1, 1'b0, 16'h2761, 8'h7E);
    bus(1'b1, 1'b0, 16'h2762, 8'h04);
    dec(1'b1, 8'h7E);
    bus(1'b1, 1'b0, 16'h2762, 8'h02);
    rdc(16'h2763, 8'h00);
    rdc(16'h2764, 8'h00);
    for (int i = 0; i < 128; i++)
      bus(1'b1, 1'b0, 16'h2760, 8'(i));
    rdc(16'h2764, 8'h80);
    bus(1'b1, 1'b0, 16'h2760, 8'hEE);
    rdc(16'h2766, 8'h02);
    for (int i = 0; i < 128; i++)
      rdc(16'h2760, 8'(i));
    rdc(16'h2763, 8'h80);
    bus(1'b1, 1'b0, 16'h2766, 8'hFF);
    bus(1'b1, 1'b0, 16'h2761, 8'h5A);
    bus(1'b1, 1'b0, 16'h2762, 8'h01);
    poll(16'h276A, 8'h10, 8'h00, n);
    chk(8'(n), 8'h80);
    rdc(16'h2766, 8'h08);
    bus(1'b1, 1'b0, 16'h2763, 8'h00);
    rdc(16'h2760, 8'h5A);
    bus(1'b1, 1'b0, 16'h2763, 8'h7F);
    rdc(16'h2760, 8'h5A);
    // Far side stalls first so the DMA must wait for data
    bus(1'b1, 1'b0, 16'h2766, 8'hFF);
    bus(1'b1, 1'b0, 16'h2762, 8'h02);
    bus(1'b1, 1'b0, 16'h2765, 8'h03);
    mac.load(8'hC1);
    mac.load(8'hC2);
    mac.load(8'hC3);
    mac.load(8'hC4);
    stall <= 1'b1;
    bus(1'b1, 1'b0, 16'h2762, 8'h08);
    rdc(16'h2762, 8'h00);
    idle(4);
    stall <= 1'b0;
    bus(1'b1, 1'b0, 16'h2767, 8'h01);
    poll(16'h2766, 8'h01, 8'h01, n);
    rdc(16'h2764, 8'h03);
    chk(8'(pops), 8'h03);
    chk({7'h00, mrx_valid}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    rdc(16'h2760, 8'hC1);
    rdc(16'h2760, 8'hC2);
    rdc(16'h2760, 8'hC3);
    idle(1);
    results();
  end
endmodule : tb_top
`default_nettype wire
